//--- hw/cdi_pkg.sv
// constants, types and helpers shared by the current dac serial slave port
package cdi_pkg;

	// ==========================================================
	// sizes and reset values
	localparam int         CHANNELS_DEF  = 4;
	localparam int         MAG_W         = 7;
	localparam int         SIGN_BIT      = 7;
	localparam logic [7:0] OUT_REG_RESET = 8'h00;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// ==========================================================
	// memory map: first output control register, channels follow it
	localparam logic [7:0] MEM_ADDR_BASE = 8'hF8;

	// ==========================================================
	// slave address: two select pins on top, fixed low five bits
	localparam logic [4:0] SLV_ADDR_FIXED = 5'h10;

	// ==========================================================
	// bit counting within one byte
	localparam logic [3:0] RX_LAST_BIT   = 4'h7;
	localparam logic [3:0] TX_BYTE_DONE  = 4'h8;
	localparam logic [3:0] TX_FIRST_CNT  = 4'h1;

	// ==========================================================
	// types
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RX,
		ST_RX_ACK,
		ST_TX,
		ST_TX_ACK
	} cdi_state_t;

	typedef enum logic [1:0] {
		BY_SLAVE,
		BY_MEM,
		BY_DATA
	} cdi_byte_t;

	// seven-bit own address from the two select pin levels
	function automatic logic [6:0] cdi_own_addr(input logic a_hi, input logic a_lo);
		return {a_hi, a_lo, SLV_ADDR_FIXED};
	endfunction

endpackage

//--- hw/cdi_slave_port.sv
// two-wire serial slave port with output control registers for a current dac
`timescale 1ns/1ns
`default_nettype none

module cdi_slave_port #(
	parameter int CHANNELS = cdi_pkg::CHANNELS_DEF
) (
	// clock, reset, enable
	input  wire logic                                 REF_CLK,
	input  wire logic                                 RSTN,
	input  wire logic                                 CE,
	// serial bus (open drain data, low enable drives)
	input  wire logic                                 SCL_IN,
	input  wire logic                                 SDA_IN,
	output var  logic                                 SDA_OUT,
	output var  logic                                 SDA_OE_N,
	// address-select pins
	input  wire logic                                 ADDR_SELECT_LOW_PIN,
	input  wire logic                                 ADDR_SELECT_HIGH_PIN,
	// per-channel current controls
	output wire logic [CHANNELS*cdi_pkg::MAG_W-1:0]   CURRENT_MAGNITUDE_CODE,
	output wire logic [CHANNELS-1:0]                  CURRENT_SOURCE_DIR,
	output wire logic [CHANNELS-1:0]                  CURRENT_OUTPUT_EN
);
	import cdi_pkg::*;

	localparam int CH_W = (CHANNELS > 1) ? $clog2(CHANNELS) : 1;

	// ==========================================================
	// declarations
	logic              scl_s;
	logic              sda_s;
	logic              ahi_s;
	logic              alo_s;
	logic              scl_prev_q;
	logic              sda_prev_q;
	logic              start_ev;
	logic              stop_ev;
	logic              rise_ev;
	logic              fall_ev;
	cdi_state_t        state_q;
	cdi_byte_t         kind_q;
	logic [3:0]        bit_cnt_q;
	logic [7:0]        shift_q;
	logic [7:0]        tx_q;
	logic [7:0]        ptr_q;
	logic              rw_q;
	logic              ninth_q;
	logic              m_ack_q;
	logic              sda_oe_n_q;
	logic              sda_out_q;
	logic [7:0]        rx_byte;
	logic              addr_hit;
	logic              ch_ok;
	logic [CH_W-1:0]   ch_idx;
	logic [7:0]        read_val;
	logic              wr_commit;
	logic [7:0]        reg_q [CHANNELS];
	logic [CHANNELS-1:0] en_q;

	// ==========================================================
	// pin synchronisers
	cdi_sync #(
		.WIDTH(4)
	) u_sync (
		.clk   (REF_CLK),
		.rst_n (RSTN),
		.ce    (CE),
		.d     ({SCL_IN, SDA_IN, ADDR_SELECT_HIGH_PIN, ADDR_SELECT_LOW_PIN}),
		.q     ({scl_s, sda_s, ahi_s, alo_s})
	);

	// ==========================================================
	// bus condition detection
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else if (CE) begin
			scl_prev_q <= scl_s;
			sda_prev_q <= sda_s;
		end
	end

	// data edges only count as conditions while scl stays high
	assign start_ev = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
	assign stop_ev  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
	assign rise_ev  = scl_s & ~scl_prev_q;
	assign fall_ev  = ~scl_s & scl_prev_q;

	// ==========================================================
	// byte and address decode
	assign rx_byte  = {shift_q[6:0], sda_s};
	assign addr_hit = (rx_byte[7:1] == cdi_own_addr(ahi_s, alo_s));

	// unmapped memory addresses neither write nor read a register
	assign ch_ok    = (ptr_q >= MEM_ADDR_BASE) &&
	                  (({1'b0, ptr_q} - {1'b0, MEM_ADDR_BASE}) < 9'(CHANNELS));
	assign ch_idx   = CH_W'(ptr_q - MEM_ADDR_BASE);
	assign read_val = ch_ok ? reg_q[ch_idx] : UNMAPPED_READ;

	// the write lands as the ack starts, so a nack never happens
	assign wr_commit = (state_q == ST_RX_ACK) && !ninth_q && fall_ev &&
	                   (kind_q == BY_DATA) && ch_ok;

	// ==========================================================
	// transfer state machine
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			state_q    <= ST_IDLE;
			kind_q     <= BY_SLAVE;
			bit_cnt_q  <= 4'h0;
			shift_q    <= 8'h00;
			tx_q       <= 8'h00;
			ptr_q      <= MEM_ADDR_BASE;
			rw_q       <= 1'b0;
			ninth_q    <= 1'b0;
			m_ack_q    <= 1'b0;
			sda_oe_n_q <= 1'b1;
		end else if (CE) begin
			if (start_ev) begin
				// restart mid-transfer too, and let go of the line
				state_q    <= ST_RX;
				kind_q     <= BY_SLAVE;
				bit_cnt_q  <= 4'h0;
				ninth_q    <= 1'b0;
				sda_oe_n_q <= 1'b1;
			end else if (stop_ev) begin
				state_q    <= ST_IDLE;
				sda_oe_n_q <= 1'b1;
			end else begin
				case (state_q)
					ST_IDLE: begin
						// waits for a start; also the parking state after a mismatch
						sda_oe_n_q <= 1'b1;
					end
					ST_RX: begin
						if (rise_ev) begin
							shift_q   <= rx_byte;
							bit_cnt_q <= bit_cnt_q + 4'h1;
							if (bit_cnt_q == RX_LAST_BIT) begin
								ninth_q <= 1'b0;
								if (kind_q == BY_SLAVE) begin
									if (addr_hit) begin
										rw_q    <= sda_s;
										state_q <= ST_RX_ACK;
									end else begin
										state_q <= ST_IDLE;
									end
								end else begin
									if (kind_q == BY_MEM) begin
										ptr_q <= rx_byte;
									end
									state_q <= ST_RX_ACK;
								end
							end
						end
					end
					ST_RX_ACK: begin
						if (fall_ev && !ninth_q) begin
							sda_oe_n_q <= 1'b0;
							ninth_q    <= 1'b1;
						end else if (fall_ev) begin
							ninth_q <= 1'b0;
							if (kind_q == BY_SLAVE && rw_q) begin
								// first read bit goes out on the ack's closing fall
								state_q    <= ST_TX;
								sda_oe_n_q <= read_val[7];
								tx_q       <= {read_val[6:0], 1'b0};
								bit_cnt_q  <= TX_FIRST_CNT;
							end else begin
								state_q    <= ST_RX;
								sda_oe_n_q <= 1'b1;
								bit_cnt_q  <= 4'h0;
								kind_q     <= (kind_q == BY_SLAVE) ? BY_MEM : BY_DATA;
							end
						end
					end
					ST_TX: begin
						if (fall_ev) begin
							if (bit_cnt_q == TX_BYTE_DONE) begin
								// master answers the ninth bit, so float the line
								sda_oe_n_q <= 1'b1;
								state_q    <= ST_TX_ACK;
								ninth_q    <= 1'b0;
							end else begin
								sda_oe_n_q <= tx_q[7];
								tx_q       <= {tx_q[6:0], 1'b0};
								bit_cnt_q  <= bit_cnt_q + 4'h1;
							end
						end
					end
					ST_TX_ACK: begin
						if (rise_ev) begin
							m_ack_q <= ~sda_s;
							ninth_q <= 1'b1;
						end else if (fall_ev && ninth_q) begin
							ninth_q <= 1'b0;
							if (m_ack_q) begin
								// acked: repeat the same register, no auto-increment
								state_q    <= ST_TX;
								sda_oe_n_q <= read_val[7];
								tx_q       <= {read_val[6:0], 1'b0};
								bit_cnt_q  <= TX_FIRST_CNT;
							end else begin
								state_q <= ST_IDLE;
							end
						end
					end
					default: begin
						state_q <= ST_IDLE;
					end
				endcase
			end
		end
	end

	// open drain: the data value is always low, only the enable moves
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			sda_out_q <= 1'b0;
		end else if (CE) begin
			sda_out_q <= 1'b0;
		end
	end

	assign SDA_OUT  = sda_out_q;
	assign SDA_OE_N = sda_oe_n_q;

	// ==========================================================
	// output control registers
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			for (int i = 0; i < CHANNELS; i++) begin
				reg_q[i] <= OUT_REG_RESET;
			end
			en_q <= '0;
		end else if (CE && wr_commit) begin
			reg_q[ch_idx] <= shift_q;
			// enable kept beside the code so the analog side needs no compare
			en_q[ch_idx]  <= (shift_q[MAG_W-1:0] != '0);
		end
	end

	for (genvar g = 0; g < CHANNELS; g++) begin : g_out
		assign CURRENT_MAGNITUDE_CODE[g*MAG_W +: MAG_W] = reg_q[g][MAG_W-1:0];
		assign CURRENT_SOURCE_DIR[g]                    = reg_q[g][SIGN_BIT];
		assign CURRENT_OUTPUT_EN[g]                     = en_q[g];
	end

	// ==========================================================
	// checks
	chk_start_restart: assert property (
		@(posedge REF_CLK) disable iff (!RSTN)
		start_ev && CE |=> state_q == ST_RX && bit_cnt_q == 4'h0 && sda_oe_n_q
	) else $error("start did not restart reception");
	chk_stop_idle: assert property (
		@(posedge REF_CLK) disable iff (!RSTN)
		stop_ev && CE |=> state_q == ST_IDLE && sda_oe_n_q
	) else $error("stop did not return to idle");
	chk_drive_clock_low: assert property (
		@(posedge REF_CLK) disable iff (!RSTN)
		$fell(sda_oe_n_q) |-> !scl_prev_q
	) else $error("sda driven while scl high");
	chk_sample_rise: assert property (
		@(posedge REF_CLK) disable iff (!RSTN)
		state_q == ST_RX && rise_ev && CE |=> shift_q[0] == $past(sda_s)
	) else $error("bit not sampled on scl rise");
	chk_tx_bit_fall: assert property (
		@(posedge REF_CLK) disable iff (!RSTN)
		state_q == ST_TX && fall_ev && CE && bit_cnt_q < TX_BYTE_DONE
		|=> sda_oe_n_q == $past(tx_q[7])
	) else $error("sent bit not driven on scl fall");
	chk_ack_drive: assert property (
		@(posedge REF_CLK) disable iff (!RSTN)
		state_q == ST_RX_ACK && fall_ev && !ninth_q && CE
		|=> !sda_oe_n_q && state_q == ST_RX_ACK
	) else $error("ack not driven low");
	chk_nack_end: assert property (
		@(posedge REF_CLK) disable iff (!RSTN)
		state_q == ST_TX_ACK && fall_ev && ninth_q && !m_ack_q && CE
		|=> state_q == ST_IDLE && sda_oe_n_q
	) else $error("nack did not end the read");
	chk_master_ack_free: assert property (
		@(posedge REF_CLK) disable iff (!RSTN)
		state_q == ST_TX_ACK |-> sda_oe_n_q
	) else $error("sda held during master ack bit");
	chk_dir_capture: assert property (
		@(posedge REF_CLK) disable iff (!RSTN)
		state_q == ST_RX && rise_ev && CE && bit_cnt_q == RX_LAST_BIT &&
		kind_q == BY_SLAVE && addr_hit |=> rw_q == $past(sda_s)
	) else $error("direction bit not captured");
	chk_addr_miss: assert property (
		@(posedge REF_CLK) disable iff (!RSTN)
		state_q == ST_RX && rise_ev && CE && bit_cnt_q == RX_LAST_BIT &&
		kind_q == BY_SLAVE && !addr_hit |=> state_q == ST_IDLE ##1 sda_oe_n_q
	) else $error("mismatched address not ignored");
	chk_reg_write: assert property (
		@(posedge REF_CLK) disable iff (!RSTN)
		wr_commit && CE |=> reg_q[$past(ch_idx)] == $past(shift_q)
	) else $error("data byte not stored");
	chk_zero_mag: assert property (
		@(posedge REF_CLK) disable iff (!RSTN)
		CURRENT_OUTPUT_EN[0] == (CURRENT_MAGNITUDE_CODE[MAG_W-1:0] != '0)
	) else $error("output enable disagrees with magnitude");

endmodule

`default_nettype wire

//--- hw/cdi_sync.sv
// two-flop synchroniser for the bus and address-select pins
`timescale 1ns/1ns
`default_nettype none

module cdi_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             ce,
	// asynchronous levels in, synchronised levels out
	input  wire logic [WIDTH-1:0] d,
	output var  logic [WIDTH-1:0] q
);

	// ==========================================================
	// stage one is read only by stage two
	logic [WIDTH-1:0] meta_q;

	// idle bus lines are high, so reset to high avoids a false start
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= {WIDTH{1'b1}};
			q      <= {WIDTH{1'b1}};
		end else if (ce) begin
			meta_q <= d;
			q      <= meta_q;
		end
	end

endmodule

`default_nettype wire

//--- test/cdi_bus_master.sv
// two-wire bus master model that drives the slave port's serial pins
`timescale 1ns/1ns
`default_nettype none

module cdi_bus_master (
	// clock and resolved data wire
	input  wire logic clk,
	input  wire logic sda,
	// pins driven by the master
	output var  logic scl,
	output var  logic sda_low
);
	// cycles per clock phase; raised to play a slow master
	int ph_len = 5;

	// ======
	// idle bus: clock high, data released to its pull-up
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	task automatic ph();
		repeat (ph_len) @(posedge clk);
	endtask

	// start and repeated start are the same shape on the wire
	task automatic start();
		sda_low <= 1'b0;
		ph();
		scl <= 1'b1;
		ph();
		sda_low <= 1'b1;
		ph();
		scl <= 1'b0;
		ph();
	endtask

	task automatic stop();
		sda_low <= 1'b1;
		ph();
		scl <= 1'b1;
		ph();
		sda_low <= 1'b0;
		ph();
	endtask

	// data changes only with clock low, held over the whole high phase
	task automatic bit_io(input logic b, output logic r);
		sda_low <= !b;
		ph();
		scl <= 1'b1;
		ph();
		r = sda;
		scl <= 1'b0;
		ph();
	endtask

	// eight bits msb first, then the receiver's answer on bit nine
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
		end
		bit_io(1'b1, r);
		ack = !r;
	endtask

	task automatic rd_byte(input logic more, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(!more, r);
	endtask
endmodule

`default_nettype wire

//--- test/cdi_slave_port_tb_top.sv
// self-checking bench for the current dac serial slave port
`timescale 1ns/1ns
`default_nettype none

`define CHK(nm, ex, got) \
	begin \
		tests_run++; \
		if ((got) !== (ex)) begin \
			num_errors++; \
			$display("mismatch %s exp %h got %h", nm, (ex), (got)); \
		end \
	end

module cdi_slave_port_tb_top;
	import cdi_pkg::*;

	localparam int         CH       = 4;
	localparam logic [7:0] ADDR8 [4] = '{8'h20, 8'h60, 8'hA0, 8'hE0};
	localparam logic [7:0] WM [6]    = '{8'hF9, 8'hFA, 8'hFB, 8'hF8, 8'hFC, 8'h00};
	localparam logic [7:0] WD [6]    = '{8'h80, 8'h7F, 8'h00, 8'h2A, 8'h55, 8'h55};

	// ======
	// signals and bookkeeping
	logic                clk;
	logic                rst_n;
	logic                ce;
	logic                a_lo;
	logic                a_hi;
	logic                scl;
	logic                mst_low;
	logic                sda_out;
	logic                sda_oe_n;
	wire  logic          sda;
	logic [CH*MAG_W-1:0] mag;
	logic [CH-1:0]       dir;
	logic [CH-1:0]       en;
	logic [7:0]          shadow [CH];
	int                  num_errors = 0;
	int                  tests_run = 0;

	// open drain wire with pull-up: low if either side pulls
	assign sda = mst_low ? 1'b0 : (sda_oe_n ? 1'b1 : sda_out);

	cdi_slave_port #(.CHANNELS(CH)) uut (
		.REF_CLK                (clk),
		.RSTN                   (rst_n),
		.CE                     (ce),
		.SCL_IN                 (scl),
		.SDA_IN                 (sda),
		.SDA_OUT                (sda_out),
		.SDA_OE_N               (sda_oe_n),
		.ADDR_SELECT_LOW_PIN    (a_lo),
		.ADDR_SELECT_HIGH_PIN   (a_hi),
		.CURRENT_MAGNITUDE_CODE (mag),
		.CURRENT_SOURCE_DIR     (dir),
		.CURRENT_OUTPUT_EN      (en)
	);

	cdi_bus_master mst (
		.clk     (clk),
		.sda     (sda),
		.scl     (scl),
		.sda_low (mst_low)
	);

	// ======
	// 125 MHz clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic results();
		if (num_errors == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// whole run needs about 16k cycles; two and a half times that means a hang
	initial begin
		repeat (40000) @(posedge clk);
		num_errors++;
		results();
	end

	// channel outputs against the expected register images
	task automatic chk_regs();
		for (int g = 0; g < CH; g++) begin
			`CHK("mag", shadow[g][6:0], mag[g*MAG_W +: MAG_W])
			`CHK("dir", shadow[g][SIGN_BIT], dir[g])
			`CHK("en", shadow[g][6:0] != 7'h00, en[g])
		end
	endtask

	task automatic wr_reg(input logic [6:0] sa, input logic [7:0] ma, input logic [7:0] d,
		output logic [2:0] a);
		mst.start();
		mst.wr_byte({sa, 1'b0}, a[2]);
		mst.wr_byte(ma, a[1]);
		mst.wr_byte(d, a[0]);
		mst.stop();
	endtask

	task automatic t_reset();
		`CHK("idle oe_n", 1'b1, sda_oe_n)
		`CHK("sda value", 1'b0, sda_out)
		chk_regs();
	endtask

	// every pin setting against every address; only the match answers
	task automatic t_addr();
		logic [2:0] a;
		logic [7:0] d;
		for (int k = 0; k < 4; k++) begin
			{a_hi, a_lo} <= 2'(k);
			repeat (4) @(posedge clk);
			for (int s = 0; s < 4; s++) begin
				d = 8'h81 + 8'(k * 16 + s);
				wr_reg(ADDR8[s][7:1], 8'hF8 + 8'(k), d, a);
				if (s == k) begin
					shadow[k] = d;
				end
				`CHK("acks", (s == k) ? 3'b111 : 3'b000, a)
				chk_regs();
			end
		end
		{a_hi, a_lo} <= 2'b00;
		repeat (4) @(posedge clk);
	endtask

	// zero magnitude with sign set, full scale, unmapped addresses
	task automatic t_write();
		logic [2:0] a;
		logic [7:0] off;
		logic [3:0] b;
		for (int i = 0; i < 6; i++) begin
			wr_reg(ADDR8[0][7:1], WM[i], WD[i], a);
			off = WM[i] - 8'hF8;
			if (off < 8'(CH)) begin
				shadow[off] = WD[i];
			end
			`CHK("wr acks", 3'b111, a)
			chk_regs();
		end
		// further data bytes rewrite the same register, no increment
		mst.start();
		mst.wr_byte({ADDR8[0][7:1], 1'b0}, b[3]);
		mst.wr_byte(MEM_ADDR_BASE + 8'h01, b[2]);
		mst.wr_byte(8'h01, b[1]);
		mst.wr_byte(8'h85, b[0]);
		mst.stop();
		shadow[1] = 8'h85;
		`CHK("multi acks", 4'hF, b)
		chk_regs();
	endtask

	// pointer set, repeated start, ack then nack; last channel slow
	task automatic t_read();
		logic [2:0] a;
		logic [7:0] d1;
		logic [7:0] d2;
		logic [7:0] ex;
		// one pass beyond the last channel reads an unmapped address
		for (int g = 0; g <= CH; g++) begin
			ex = (g < CH) ? shadow[g] : UNMAPPED_READ;
			mst.ph_len = (g == CH - 1) ? 12 : 5;
			mst.start();
			mst.wr_byte({ADDR8[0][7:1], 1'b0}, a[2]);
			mst.wr_byte(8'hF8 + 8'(g), a[1]);
			mst.start();
			mst.wr_byte({ADDR8[0][7:1], 1'b1}, a[0]);
			mst.rd_byte(1'b1, d1);
			mst.rd_byte(1'b0, d2);
			mst.stop();
			`CHK("rd acks", 3'b111, a)
			`CHK("rd byte", ex, d1)
			`CHK("rd again", ex, d2)
			`CHK("released", 1'b1, sda_oe_n)
		end
		mst.ph_len = 5;
	endtask

	// data byte cut after four bits by a repeated start
	task automatic t_abort();
		logic [2:0] a;
		logic r;
		mst.start();
		mst.wr_byte({ADDR8[0][7:1], 1'b0}, a[2]);
		mst.wr_byte(8'hF8, a[1]);
		for (int i = 0; i < 4; i++) begin
			mst.bit_io(1'b1, r);
		end
		mst.start();
		mst.stop();
		`CHK("cut acks", 2'b11, a[2:1])
		chk_regs();
	endtask

	// clock enable low: a whole write passes by unseen
	task automatic t_freeze();
		logic [2:0] a;
		ce <= 1'b0;
		wr_reg(ADDR8[0][7:1], MEM_ADDR_BASE, 8'h3C, a);
		ce <= 1'b1;
		repeat (4) @(posedge clk);
		`CHK("frozen acks", 3'b000, a)
		chk_regs();
	endtask

	// ======
	// reset, then the scenarios in turn
	initial begin
		rst_n = 1'b0;
		ce = 1'b1;
		a_lo = 1'b0;
		a_hi = 1'b0;
		shadow = '{default: 8'h00};
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		t_reset();
		t_addr();
		t_write();
		t_read();
		t_abort();
		t_freeze();
		// reset again mid-run: everything back to power-up values
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		shadow = '{default: OUT_REG_RESET};
		repeat (4) @(posedge clk);
		t_reset();
		results();
	end
endmodule

`default_nettype wire
